// File: crs_defines.svh
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH
// ==========================================
// timing
`define CRS_CLK_MHZ 100
`define CRS_MOD_DIV 2
`define CRS_WAIT_MOD (256 + 44)
`define CRS_WAIT_CYC (`CRS_WAIT_MOD * `CRS_MOD_DIV)
`define CRS_OSR 1024
`define CRS_DATA_CYC (`CRS_OSR * `CRS_MOD_DIV)
`define CRS_SET1_MOD 1324
`define CRS_SET1_CYC (`CRS_SET1_MOD * `CRS_MOD_DIV)
`define CRS_SET3_MOD 3372
`define CRS_SET3_CYC (`CRS_SET3_MOD * `CRS_MOD_DIV)
`define CRS_ACQ_NS 5000
`define CRS_ACQ_CYC ((`CRS_ACQ_NS * `CRS_CLK_MHZ + 999) / 1000)
`define CRS_RPW_NS 2000
`define CRS_RPW_CYC ((`CRS_RPW_NS * `CRS_CLK_MHZ + 999) / 1000)
// ==========================================
// frame
`define CRS_FRAME_BITS 7'h60
`define CRS_CRC_BITS 7'h48
`define CRS_CMD_RESET 16'h0011
`define CRS_CMD_REGISTER_WRITE_COMMAND 3'h3
`define CRS_ACK_REGISTER_WRITE_COMMAND 3'h2
// ==========================================
// crc
`define CRS_SEED 16'hffff
`define CRS_POLY_CCITT 16'h1021
`define CRS_POLY_ANSI 16'h8005
`define CRS_MAP_LAST_BIT 9'h10f
// ==========================================
// register map
`define CRS_ADDR_STATUS 6'h01
`define CRS_MAP_FIRST 6'h02
`define CRS_MAP_LAST 6'h12
`define CRS_ADDR_MAPCRC 6'h13
`define CRS_I_MODE 5'h00
`define CRS_I_OCAL0_M 5'h07
`define CRS_I_OCAL0_L 5'h08
`define CRS_I_GCAL0_M 5'h09
`define CRS_I_GCAL0_L 5'h0a
`define CRS_I_OCAL1_M 5'h0c
`define CRS_I_OCAL1_L 5'h0d
`define CRS_I_GCAL1_M 5'h0e
`define CRS_I_GCAL1_L 5'h0f
`define CRS_MODE_REG_CRC_EN 13
`define CRS_MODE_RX_CRC_EN 12
`define CRS_MODE_CRC_TYPE 11
`define CRS_ST_MAP 13
`define CRS_ST_CRC_ERR 12
`define CRS_RST_MODE 16'h0000
`define CRS_RST_OCAL 16'h0000
`define CRS_RST_GCAL_M 16'h8000
`endif

// File: crs_pkg.sv
`include "crs_defines.svh"
package crs_pkg;
  typedef enum logic [1:0] {PH_RST, PH_WAIT, PH_RUN} crs_phase_t;

  typedef struct packed {
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic sclk_prev;
    logic cs_prev;
    logic [7:0] pin_cnt;
    crs_phase_t ph;
    logic [11:0] tcnt;
    logic [1:0] nsamp;
    logic fast;
    logic smp;
    logic spi_rdy;
    logic data_ready_pin_n;
    logic [16:0][15:0] regs;
    logic [6:0] bcnt;
    logic [95:0] rx;
    logic [95:0] tx;
    logic [15:0] rcrc;
    logic [15:0] tcrc;
    logic [15:0] resp;
    logic resp_stat;
    logic crc_err;
    logic map_chg;
    logic [8:0] mcnt;
    logic [15:0] mcrc;
    logic [15:0] mres;
    logic mvalid;
    logic [23:0] d0;
    logic [23:0] d1;
    logic [15:0] rdata;
  } crs_state_t;

  function automatic logic [15:0] crs_crc_bit(input logic [15:0] c,
      input logic b, input logic ansi);
    logic [15:0] poly;
    poly = ansi ? `CRS_POLY_ANSI : `CRS_POLY_CCITT;
    crs_crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? poly : 16'h0000);
  endfunction : crs_crc_bit
endpackage : crs_pkg

// File: crs_core.sv
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "crs_defines.svh"
// ==========================================
// How it works
// - offset always applied; per-channel offset resets to zero
// - per-channel gain resets to 800000h, a factor of one
// - result is (raw minus signed offset) times unsigned gain over 2^23
// - 16-bit frame crc covers the first three words of the frame incl. pad bits
// - input crc check enabled by a mode bit, off after reset
// - on bad input crc only the register write command still executes
// - crc error sets status flag; next frame answers with status word
// - crc error flag clears when status is loaded at cs fall, or on status read
// - output crc always sent as the last word of every frame
// - one mode bit picks ccitt or ansi polynomial for both directions
// - every crc starts from all ones
// - map crc runs over registers 02h to 12h msb first when enabled
// - map crc takes one bit per clock, stores result, compares previous
// - map change flag set on differing crc, cleared by status read/out
// - all resets restore defaults; data-ready rise marks spi usable
// - sync pin low beyond pulse width holds reset until it rises
// - reset command acts only when its full four-word frame completes
// - reset command resets at once; host waits acquisition time
// - modulators wait 256+44 periods before feeding the filters
// - fast filter gives first two samples, sinc3 path the rest
// - first settled sample at 1324, first sinc3 at 3372 periods
// - pin and command reset repeat the startup wait and fast samples
module crs_core import crs_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [5:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_sync_rst_n,
  output logic o_data_ready_pin,
  input wire logic [23:0] i_fast_ch0,
  input wire logic [23:0] i_fast_ch1,
  input wire logic [23:0] i_sinc_ch0,
  input wire logic [23:0] i_sinc_ch1,
  output logic o_filt_feed,
  output logic o_sample,
  output logic o_fast_sel,
  output logic [23:0] o_ch0_data,
  output logic [23:0] o_ch1_data
);
  crs_state_t q;
  crs_state_t n;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic frame_ok;
  logic bad;
  logic cmd_rst;
  logic pin_rst;
  logic [15:0] fcmd;
  logic [15:0] fdat;
  logic [4:0] fidx;
  logic [12:0] since_q;

  // ==========================================
  // defaults and correction math
  function automatic crs_state_t rst_val();
    crs_state_t r;
    r = '0;
    r.sy1 = 4'ha;
    r.sy2 = 4'ha;
    r.cs_prev = 1'b1;
    r.regs[`CRS_I_MODE] = `CRS_RST_MODE;
    r.regs[`CRS_I_OCAL0_M] = `CRS_RST_OCAL;
    r.regs[`CRS_I_OCAL1_M] = `CRS_RST_OCAL;
    r.regs[`CRS_I_GCAL0_M] = `CRS_RST_GCAL_M;
    r.regs[`CRS_I_GCAL1_M] = `CRS_RST_GCAL_M;
    r.ph = PH_WAIT;
    r.rcrc = `CRS_SEED;
    r.tcrc = `CRS_SEED;
    r.mcrc = `CRS_SEED;
    r.resp_stat = 1'b1;
    return r;
  endfunction : rst_val

  function automatic logic [23:0] corr(input logic [23:0] raw,
      input logic [23:0] off, input logic [23:0] gain);
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [49:0] sh;
    diff = $signed({raw[23], raw}) - $signed({off[23], off});
    prod = diff * $signed({1'b0, gain});
    sh = prod >>> 23;
    if (sh > 50'sh7fffff) begin
      corr = 24'h7fffff;
    end else if (sh < -50'sh800000) begin
      corr = 24'h800000;
    end else begin
      corr = sh[23:0];
    end
  endfunction : corr

  // ==========================================
  // next state
  always_comb begin
    logic [15:0] stat;
    logic [15:0] crc_n;
    logic ansi;
    logic [23:0] raw0;
    logic [23:0] raw1;
    n = q;
    n.sy1 = {i_sync_rst_n, i_mosi, i_cs_n, i_sclk};
    n.sy2 = q.sy1;
    n.sclk_prev = q.sy2[0];
    n.cs_prev = q.sy2[1];
    n.smp = 1'b0;
    n.rdata = 16'h0000;
    ansi = q.regs[`CRS_I_MODE][`CRS_MODE_CRC_TYPE];
    sclk_fall = q.sclk_prev & ~q.sy2[0];
    cs_fall = q.cs_prev & ~q.sy2[1];
    cs_rise = ~q.cs_prev & q.sy2[1];
    fcmd = q.rx[95:80];
    fdat = q.rx[71:56];
    fidx = 5'(fcmd[12:7] - `CRS_MAP_FIRST);
    frame_ok = q.spi_rdy & cs_rise & (q.bcnt == `CRS_FRAME_BITS);
    bad = q.regs[`CRS_I_MODE][`CRS_MODE_RX_CRC_EN] &
          (q.rcrc != q.rx[23:8]);
    cmd_rst = 1'b0;
    stat = 16'h0000;
    stat[`CRS_ST_CRC_ERR] = q.crc_err;
    stat[`CRS_ST_MAP] = q.map_chg;
    raw0 = q.fast ? i_fast_ch0 : i_sinc_ch0;
    raw1 = q.fast ? i_fast_ch1 : i_sinc_ch1;
    crc_n = 16'h0000;

    // sync pin low-time filter
    if (q.sy2[3]) begin
      n.pin_cnt = 8'h00;
    end else if (q.pin_cnt != 8'hff) begin
      n.pin_cnt = q.pin_cnt + 8'h01;
    end
    pin_rst = ~q.sy2[3] & (q.pin_cnt >= 8'(`CRS_RPW_CYC));

    // startup sequencer
    unique case (q.ph)
      PH_RST: begin
        if (q.sy2[3]) begin
          n.ph = PH_WAIT;
          n.tcnt = 12'h000;
        end
      end
      PH_WAIT: begin
        n.tcnt = q.tcnt + 12'h001;
        if (q.tcnt == 12'(`CRS_ACQ_CYC - 1)) begin
          n.spi_rdy = 1'b1;
          n.data_ready_pin_n = 1'b1;
        end
        if (q.tcnt == 12'(`CRS_WAIT_CYC - 1)) begin
          n.ph = PH_RUN;
          n.tcnt = 12'h000;
        end
      end
      PH_RUN: begin
        n.tcnt = q.tcnt + 12'h001;
        if (q.tcnt == 12'(`CRS_DATA_CYC - 1)) begin
          n.tcnt = 12'h000;
          n.smp = 1'b1;
          n.data_ready_pin_n = 1'b0;
          n.fast = (q.nsamp < 2'h2);
          if (q.nsamp != 2'h3) begin
            n.nsamp = q.nsamp + 2'h1;
          end
          raw0 = (q.nsamp < 2'h2) ? i_fast_ch0 : i_sinc_ch0;
          raw1 = (q.nsamp < 2'h2) ? i_fast_ch1 : i_sinc_ch1;
          n.d0 = corr(raw0, {q.regs[`CRS_I_OCAL0_M],
                 q.regs[`CRS_I_OCAL0_L][15:8]},
                 {q.regs[`CRS_I_GCAL0_M],
                 q.regs[`CRS_I_GCAL0_L][15:8]});
          n.d1 = corr(raw1, {q.regs[`CRS_I_OCAL1_M],
                 q.regs[`CRS_I_OCAL1_L][15:8]},
                 {q.regs[`CRS_I_GCAL1_M],
                 q.regs[`CRS_I_GCAL1_L][15:8]});
        end
      end
    endcase

    // register port
    if (i_wr && i_addr >= `CRS_MAP_FIRST && i_addr <= `CRS_MAP_LAST) begin
      n.regs[5'(i_addr - `CRS_MAP_FIRST)] = i_wdata;
    end
    if (i_rd) begin
      if (i_addr == `CRS_ADDR_STATUS) begin
        n.rdata = stat;
        n.crc_err = 1'b0;
        n.map_chg = 1'b0;
      end else if (i_addr >= `CRS_MAP_FIRST && i_addr <= `CRS_MAP_LAST) begin
        n.rdata = q.regs[5'(i_addr - `CRS_MAP_FIRST)];
      end else if (i_addr == `CRS_ADDR_MAPCRC) begin
        n.rdata = q.mres;
      end
    end

    // spi frame engine, traffic ignored until ready
    if (q.spi_rdy && cs_fall) begin
      n.bcnt = 7'h00;
      n.rcrc = `CRS_SEED;
      n.tcrc = `CRS_SEED;
      n.data_ready_pin_n = 1'b1;
      n.tx = {q.resp_stat ? stat : q.resp, 8'h00, q.d0, q.d1, 24'h000000};
      if (q.resp_stat) begin
        n.crc_err = 1'b0;
        n.map_chg = 1'b0;
      end
    end else if (q.spi_rdy && !q.sy2[1] && sclk_fall &&
                 q.bcnt < `CRS_FRAME_BITS) begin
      n.rx = {q.rx[94:0], q.sy2[2]};
      n.tx = {q.tx[94:0], 1'b0};
      n.bcnt = q.bcnt + 7'h01;
      if (q.bcnt < `CRS_CRC_BITS) begin
        n.rcrc = crs_crc_bit(q.rcrc, q.sy2[2], ansi);
        crc_n = crs_crc_bit(q.tcrc, q.tx[95], ansi);
        n.tcrc = crc_n;
        if (q.bcnt == `CRS_CRC_BITS - 7'h01) begin
          n.tx[95:72] = {crc_n, 8'h00};
        end
      end
    end else if (q.spi_rdy && cs_rise) begin
      n.resp_stat = 1'b1;
      if (frame_ok) begin
        if (fcmd[15:13] == `CRS_CMD_REGISTER_WRITE_COMMAND && fcmd[12:7] >= `CRS_MAP_FIRST &&
            fcmd[12:7] <= `CRS_MAP_LAST) begin
          n.regs[fidx] = fdat;
          if (!bad) begin
            n.resp = {`CRS_ACK_REGISTER_WRITE_COMMAND, fcmd[12:7], 7'h00};
            n.resp_stat = 1'b0;
          end
        end
        if (fcmd == `CRS_CMD_RESET && !bad) begin
          cmd_rst = 1'b1;
        end
        if (bad) begin
          n.crc_err = 1'b1;
        end
      end
    end

    // register map crc walker
    if (q.regs[`CRS_I_MODE][`CRS_MODE_REG_CRC_EN]) begin
      crc_n = crs_crc_bit(q.mcrc, q.regs[q.mcnt[8:4]][~q.mcnt[3:0]],
                          ansi);
      n.mcrc = crc_n;
      n.mcnt = q.mcnt + 9'h001;
      if (q.mcnt == `CRS_MAP_LAST_BIT) begin
        n.mcnt = 9'h000;
        n.mcrc = `CRS_SEED;
        n.mres = crc_n;
        n.mvalid = 1'b1;
        if (q.mvalid && crc_n != q.mres) begin
          n.map_chg = 1'b1;
        end
      end
    end else begin
      n.mcnt = 9'h000;
      n.mcrc = `CRS_SEED;
      n.mvalid = 1'b0;
    end

    // pin and command resets
    if (pin_rst || cmd_rst) begin
      n = rst_val();
      n.sy1 = {i_sync_rst_n, i_mosi, i_cs_n, i_sclk};
      n.sy2 = q.sy1;
      n.sclk_prev = q.sy2[0];
      n.cs_prev = q.sy2[1];
      n.pin_cnt = q.sy2[3] ? 8'h00 : q.pin_cnt;
      if (pin_rst) begin
        n.ph = PH_RST;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      q <= rst_val();
    end else if (i_ce) begin
      q <= n;
    end
  end

  // ==========================================
  // outputs
  assign o_rdata = q.rdata;
  assign o_miso = q.tx[95];
  assign o_miso_oe = q.spi_rdy & ~q.sy2[1];
  assign o_data_ready_pin = q.data_ready_pin_n;
  assign o_filt_feed = (q.ph == PH_RUN);
  assign o_sample = q.smp;
  assign o_fast_sel = q.fast;
  assign o_ch0_data = q.d0;
  assign o_ch1_data = q.d1;

  // ==========================================
  // checks
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || q.ph == PH_RST || (i_ce && (pin_rst || cmd_rst))) begin
      since_q <= 13'h0000;
    end else if (i_ce && since_q != 13'h1fff) begin
      since_q <= since_q + 13'h0001;
    end
  end

  sequence s_frame_end;
    i_ce && frame_ok;
  endsequence
  sequence s_bad_frame;
    s_frame_end ##0 bad;
  endsequence

  property p_off_rst;
    @(posedge i_sys_clk) i_rst |=> q.regs[`CRS_I_OCAL0_M] == 16'h0000 &&
      q.regs[`CRS_I_OCAL1_M] == 16'h0000;
  endproperty
  a_off_rst: assert property (p_off_rst) else $error("offset reset");
  property p_gain_rst;
    @(posedge i_sys_clk) i_rst |=> q.regs[`CRS_I_GCAL0_M] == 16'h8000 &&
      q.regs[`CRS_I_GCAL1_M] == 16'h8000;
  endproperty
  a_gain_rst: assert property (p_gain_rst) else $error("gain reset");
  property p_rxcrc_off;
    @(posedge i_sys_clk) i_rst |=> !q.regs[0][`CRS_MODE_RX_CRC_EN];
  endproperty
  a_rxcrc_off: assert property (p_rxcrc_off) else $error("rx crc on");
  property p_register_write_command_bad;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_bad_frame ##0 (fcmd[15:13] == `CRS_CMD_REGISTER_WRITE_COMMAND && !pin_rst &&
      fcmd[12:7] >= `CRS_MAP_FIRST && fcmd[12:7] <= `CRS_MAP_LAST)
      |=> q.regs[$past(fidx)] == $past(fdat);
  endproperty
  a_register_write_command_bad: assert property (p_register_write_command_bad) else $error("register_write_command lost");
  property p_crc_flag;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_bad_frame |=> q.crc_err && q.resp_stat;
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("crc flag");
  property p_crc_clr;
    @(posedge i_sys_clk) disable iff (i_rst)
      i_ce && q.spi_rdy && cs_fall && q.resp_stat && !pin_rst
      |=> !q.crc_err ##0 q.tx[95:80] == {2'b00, $past(q.map_chg),
      $past(q.crc_err), 12'h000};
  endproperty
  a_crc_clr: assert property (p_crc_clr) else $error("crc clear");
  property p_not_ready;
    @(posedge i_sys_clk) disable iff (i_rst)
      i_ce && !q.spi_rdy |=> q.bcnt == 7'h00;
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("early spi");
  property p_short;
    @(posedge i_sys_clk) disable iff (i_rst)
      q.spi_rdy && cs_rise && q.bcnt != `CRS_FRAME_BITS |-> !cmd_rst;
  endproperty
  a_short: assert property (p_short) else $error("short reset");
  property p_cmd_rst;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_frame_end ##0 (fcmd == `CRS_CMD_RESET && !bad && !pin_rst)
      |=> !q.spi_rdy && !q.data_ready_pin_n && q.ph == PH_WAIT && q.tcnt == 12'h000;
  endproperty
  a_cmd_rst: assert property (p_cmd_rst) else $error("cmd reset");
  property p_wait;
    @(posedge i_sys_clk) disable iff (i_rst)
      $rose(q.ph == PH_RUN) |-> since_q == 13'(`CRS_WAIT_CYC);
  endproperty
  a_wait: assert property (p_wait) else $error("modulator wait");
  property p_fast;
    @(posedge i_sys_clk) disable iff (i_rst)
      q.smp |-> q.fast == (q.nsamp < 2'h3);
  endproperty
  a_fast: assert property (p_fast) else $error("filter select");
  property p_settle;
    @(posedge i_sys_clk) disable iff (i_rst)
      q.smp && q.nsamp == 2'h1 |-> since_q == 13'(`CRS_SET1_CYC);
  endproperty
  a_settle: assert property (p_settle) else $error("settle time");
endmodule : crs_core

// File: crs_host_model.sv
`timescale 1ns/1ns
// ==========
// host spi controller, mode with sclk idle low
module crs_host_model (
  input wire logic i_clk,
  input wire logic i_miso,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi
);
  localparam int HALF = 8;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  function automatic logic [15:0] crc_step(input logic [15:0] c,
      input logic b, input logic ansi);
    logic [15:0] poly;
    poly = ansi ? 16'h8005 : 16'h1021;
    return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? poly : 16'h0000);
  endfunction : crc_step
  function automatic logic [15:0] crc72(input logic [95:0] d,
      input logic ansi);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < 72; i++) begin
      c = crc_step(c, d[95 - i], ansi);
    end
    return c;
  endfunction : crc72
  // sclk stands still outside frames
  task automatic xfer(input logic [95:0] d, input int n,
      output logic [95:0] q);
    q = '0;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (HALF) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_sclk <= 1'b1;
      o_mosi <= d[95 - i];
      repeat (HALF) @(posedge i_clk);
      o_sclk <= 1'b0;
      q[95 - i] = i_miso;
      repeat (HALF) @(posedge i_clk);
    end
    o_cs_n <= 1'b1;
    o_mosi <= ~o_mosi;
    repeat (HALF) @(posedge i_clk);
  endtask : xfer
endmodule : crs_host_model

// File: crs_core_bench.sv
`timescale 1ns/1ns
`include "crs_defines.svh"
module crs_core_bench;
  logic clk, rst, wr, rd, sclk, cs_n, mosi, sync_n, miso, oe, data_ready_pin;
  logic feed, smp, fsel;
  logic [5:0] addr;
  logic [15:0] wdata, rdata;
  logic [23:0] ch0, ch1;
  logic [95:0] r;
  int errors, n_checks;
  localparam logic [23:0] fa0 = 24'h000123;
  localparam logic [23:0] fa1 = 24'hfff000;
  localparam logic [23:0] si0 = 24'h001000;
  localparam logic [23:0] si1 = 24'hfffe00;

  crs_host_model i_host (.i_clk(clk), .i_miso(miso), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_mosi(mosi));
  crs_core i_dut (.i_sys_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(oe),
    .i_sync_rst_n(sync_n), .o_data_ready_pin(data_ready_pin), .i_fast_ch0(fa0),
    .i_fast_ch1(fa1), .i_sinc_ch0(si0), .i_sinc_ch1(si1),
    .o_filt_feed(feed), .o_sample(smp), .o_fast_sel(fsel),
    .o_ch0_data(ch0), .o_ch1_data(ch1));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========
  // helpers
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic register_write_command(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : register_write_command
  task automatic rreg(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  task automatic rchk(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] d;
    rreg(a, d);
    chk($sformatf("reg%h", a), d, e);
  endtask : rchk
  task automatic rbit(input logic [5:0] a, input int b, input logic e);
    logic [15:0] d;
    rreg(a, d);
    chk($sformatf("reg%h_bit%0d", a, b), d[b], e);
  endtask : rbit
  task automatic frm(input logic [15:0] cmd, input logic [15:0] dat,
      input logic ansi, input logic bad, input int n);
    logic [95:0] f;
    f = {cmd, 8'h00, dat, 8'h00, 48'h0};
    f[23:8] = i_host.crc72(f, ansi) ^ {15'h0, bad};
    i_host.xfer(f, n, r);
  endtask : frm
  task automatic wsmp(input int k);
    int t;
    t = 0;
    repeat (k) begin
      @(posedge clk);
      #1;
      while (smp !== 1'b1 && t < 9000) begin
        @(posedge clk);
        #1;
        t++;
      end
    end
    chk("sample_wait", t < 9000, 1);
  endtask : wsmp
  task automatic wdrdy;
    int t;
    for (t = 0; t < 700 && data_ready_pin !== 1'b1; t++) @(posedge clk);
    chk("data_ready_pin_rise", t < 700, 1);
  endtask : wdrdy
  function automatic logic [15:0] mapcrc(input logic [15:0] v5);
    logic [15:0] c, w;
    c = 16'hffff;
    for (int i = 0; i < 17; i++) begin
      w = (i == 0) ? 16'h2000 : (i == 9 || i == 14) ? 16'h8000 :
        (i == 3) ? v5 : 16'h0000;
      for (int b = 15; b >= 0; b--) c = i_host.crc_step(c, w[b], 1'b0);
    end
    return c;
  endfunction : mapcrc
  // ==========
  // scenarios
  task automatic t_start;
    int t, fr, dr, k, pend;
    int ts[3];
    fr = -1;
    dr = -1;
    k = 0;
    pend = 0;
    for (t = 0; t < 8000 && k < 3; t++) begin
      @(posedge clk);
      #1;
      if (pend) chk("data_ready_pin_fall", data_ready_pin, 0);
      pend = (smp === 1'b1);
      if (feed === 1'b1 && fr < 0) fr = t;
      if (data_ready_pin === 1'b1 && dr < 0) dr = t;
      if (smp === 1'b1) begin
        ts[k] = t;
        chk("fast_sel", fsel, k < 2);
        chk("ch0", ch0, k < 2 ? fa0 : si0);
        chk("ch1", ch1, k < 2 ? fa1 : si1);
        k++;
      end
    end
    chk("feed_at", fr >= 597 && fr <= 606, 1);
    chk("data_ready_pin_at", dr >= 497 && dr <= 506, 1);
    chk("settle1", ts[0] - fr, 2048);
    chk("t_data", ts[1] - ts[0], 2048);
    chk("settle3", ts[2] - ts[0], 4096);
  endtask : t_start
  task automatic t_dflt;
    logic [5:0] a[10] = '{6'h02, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0e, 6'h0f,
      6'h10, 6'h11, 6'h3f};
    logic [15:0] e[10] = '{16'h0, 16'h0, 16'h0, 16'h8000, 16'h0, 16'h0,
      16'h0, 16'h8000, 16'h0, 16'h0};
    for (int i = 0; i < 10; i++) rchk(a[i], e[i]);
  endtask : t_dflt
  task automatic t_calib;
    register_write_command(6'h0a, 16'h1000);
    register_write_command(6'h0b, 16'h4000);
    register_write_command(6'h10, 16'hc000);
    wsmp(2);
    chk("cal0", ch0, 24'h0007f8);
    chk("cal1", ch1, 24'hfffd00);
  endtask : t_calib
  task automatic t_crcout;
    for (int s = 0; s < 2; s++) begin
      register_write_command(6'h02, s == 1 ? 16'h0800 : 16'h0000);
      frm(16'h0000, 16'h0000, 1'b0, 1'b0, 96);
      frm(16'h0000, 16'h0000, 1'b0, 1'b0, 96);
      chk("out_crc", r[23:0], {i_host.crc72(r, s[0]), 8'h00});
      chk("w1_ch0", r[71:48], 24'h0007f8);
    end
  endtask : t_crcout
  task automatic t_badcrc;
    register_write_command(6'h02, 16'h1800);
    frm(16'h0000, 16'h0000, 1'b1, 1'b0, 96);
    frm({3'h3, 6'h03, 7'h00}, 16'habcd, 1'b1, 1'b1, 96);
    chk("rx_ok", r[80 + `CRS_ST_CRC_ERR], 0);
    frm(16'h0000, 16'h0000, 1'b1, 1'b0, 96);
    chk("crc_err", r[80 + `CRS_ST_CRC_ERR], 1);
    rbit(6'h01, `CRS_ST_CRC_ERR, 1'b0);
    rchk(6'h03, 16'habcd);
  endtask : t_badcrc
  task automatic t_cmdrst;
    frm(`CRS_CMD_RESET, 16'h0000, 1'b1, 1'b1, 96);
    rchk(6'h03, 16'habcd);
    frm(`CRS_CMD_RESET, 16'h0000, 1'b1, 1'b0, 48);
    rchk(6'h03, 16'habcd);
    frm(`CRS_CMD_RESET, 16'h0000, 1'b1, 1'b0, 96);
    chk("data_ready_pin_rst", data_ready_pin, 0);
    chk("miso_oe_rst", oe, 0);
    wdrdy();
    rchk(6'h03, 16'h0000);
    rchk(6'h02, 16'h0000);
  endtask : t_cmdrst
  task automatic t_pinrst;
    register_write_command(6'h03, 16'h1234);
    @(posedge clk);
    sync_n <= 1'b0;
    repeat (50) @(posedge clk);
    sync_n <= 1'b1;
    rchk(6'h03, 16'h1234);
    @(posedge clk);
    sync_n <= 1'b0;
    repeat (400) @(posedge clk);
    #1 chk("data_ready_pin_hold", data_ready_pin, 0);
    @(posedge clk);
    sync_n <= 1'b1;
    t_start();
    rchk(6'h03, 16'h0000);
  endtask : t_pinrst
  task automatic t_map;
    register_write_command(6'h02, 16'h2000);
    repeat (700) @(posedge clk);
    rchk(6'h13, mapcrc(16'h0000));
    rbit(6'h01, `CRS_ST_MAP, 1'b0);
    register_write_command(6'h05, 16'h0001);
    repeat (700) @(posedge clk);
    rbit(6'h01, `CRS_ST_MAP, 1'b1);
    rbit(6'h01, `CRS_ST_MAP, 1'b0);
    rchk(6'h13, mapcrc(16'h0001));
  endtask : t_map
  // ==========
  // main sequence
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 6'h00;
    wdata = 16'h0000;
    sync_n = 1'b1;
    errors = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_start();
    t_dflt();
    t_calib();
    t_crcout();
    t_badcrc();
    t_cmdrst();
    t_pinrst();
    t_map();
    end_sim();
  end
  initial begin
    #1000000;
    errors++;
    end_sim();
  end
endmodule : crs_core_bench
